//--- metering_defines.svh
// Offsets, field positions, reset values and timing counts
// Assumes a 100 MHz pclk; register index times four is the byte address
`ifndef METERING_DEFINES_SVH
`define METERING_DEFINES_SVH
`define IDX_STATE      16'hc004
`define IDX_CDT        16'hec1d
`define IDX_THR_HIGH   16'hec1e
`define IDX_THR_LOW    16'hec1f
`define IDX_MODE       16'hec20
`define THR_BITS       18
`define CDT_BITS       24
`define HS_SHIFT       14
`define THR_RESET      18'h00000
`define CDT_RESET      24'h000000
`define GAIN_C_LSB     20
`define GAIN_B_LSB     16
`define GAIN_A_LSB     12
`define COMP_C_LSB     8
`define COMP_B_LSB     4
`define COMP_A_LSB     0
`define COMP_MAX       3'h4
`define CLK_KHZ        100000
`define REFRESH_MS     80
`define SETTLE_MS      500
`define REFRESH_CYC    (`REFRESH_MS * `CLK_KHZ)
`define SETTLE_CYC     (`SETTLE_MS * `CLK_KHZ)
`endif

//--- metering_pkg.sv
// Types shared by the threshold and section state block
// Assumes metering_defines.svh supplies the numeric constants
package metering_pkg;
   typedef enum {SETTLING, SETTLED} settle_st_t;
   typedef enum {SEL_NONE, SEL_STATE, SEL_CDT, SEL_HIGH, SEL_LOW, SEL_MODE} reg_sel_t;
   typedef logic [1:0] gain_sec_t;
   typedef logic [2:0] comp_sec_t;
endpackage

//--- metering_threshold_section_state.sv
// Energy and current thresholds, section state register, APB slave
// Assumes APB master on pclk; current RMS and section inputs synchronous
// Behaviour
// - High-speed threshold is normal times 16384
// - Threshold built from separately written high, low words
// - Threshold words read with top 14 bits zero
// - Both threshold words feed configuration checksum
// - Current threshold 24-bit signed, read sign-extended
// - Checksum uses sign-extended current threshold
// - Section state register is read-only
// - Bits 21:20 phase C gain section
// - Bits 17:16 phase B gain section
// - Bits 13:12 phase A gain section
// - Three 3-bit phase compensation section fields
// - Compensation sections coded 000 through 100
// - State register refreshed every 80 ms
// - State valid only after 500 ms settling
// - Gain section from RMS versus two thresholds
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "metering_defines.svh"
module metering_threshold_section_state #(
   parameter int unsigned REFRESH_CYCLES = `REFRESH_CYC,
   parameter int unsigned SETTLE_CYCLES  = `SETTLE_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [17:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic signed [31:0] irms_a,
   input  wire logic signed [31:0] irms_b,
   input  wire logic signed [31:0] irms_c,
   input  wire logic signed [31:0] section_current_threshold_0_a,
   input  wire logic signed [31:0] section_current_threshold_0_b,
   input  wire logic signed [31:0] section_current_threshold_0_c,
   input  wire logic signed [31:0] section_current_threshold_1_a,
   input  wire logic signed [31:0] section_current_threshold_1_b,
   input  wire logic signed [31:0] section_current_threshold_1_c,
   input  wire logic [2:0]         phase_comp_section_a,
   input  wire logic [2:0]         phase_comp_section_b,
   input  wire logic [2:0]         phase_comp_section_c,
   output logic      [49:0]        energy_threshold_eff,
   output logic      [31:0]        config_checksum,
   output logic                    high_speed_mode,
   output logic                    state_valid
);

   function automatic metering_pkg::reg_sel_t reg_sel(input logic [17:0] addr);
      if (addr[1:0] != 2'h0) begin
         return metering_pkg::SEL_NONE;
      end
      case (addr[17:2])
         `IDX_STATE:    return metering_pkg::SEL_STATE;
         `IDX_CDT:      return metering_pkg::SEL_CDT;
         `IDX_THR_HIGH: return metering_pkg::SEL_HIGH;
         `IDX_THR_LOW:  return metering_pkg::SEL_LOW;
         `IDX_MODE:     return metering_pkg::SEL_MODE;
         default:       return metering_pkg::SEL_NONE;
      endcase
   endfunction

   function automatic metering_pkg::gain_sec_t gain_section(
      input logic signed [31:0] irms,
      input logic signed [31:0] thr0,
      input logic signed [31:0] thr1);
      if (irms < thr0) begin
         return 2'h0;
      end else if (irms <= thr1) begin
         return 2'h1;
      end
      return 2'h2;
   endfunction

   function automatic metering_pkg::comp_sec_t comp_clamp(input logic [2:0] sec);
      return (sec > `COMP_MAX) ? `COMP_MAX : sec;
   endfunction

   logic [`THR_BITS-1:0]      thr_high;
   logic [`THR_BITS-1:0]      thr_low;
   logic [`CDT_BITS-1:0]      cdt;
   logic [31:0]               calibration_section_state;
   logic [31:0]               refresh_count;
   logic [31:0]               settle_count;
   metering_pkg::settle_st_t  settle_st;
   logic [`THR_BITS-1:0]      next_thr_high;
   logic [`THR_BITS-1:0]      next_thr_low;
   logic [`CDT_BITS-1:0]      next_cdt;
   logic                      next_high_speed_mode;
   logic [31:0]               next_prdata;
   logic                      next_pready;
   logic                      next_pslverr;
   logic [49:0]               next_energy_threshold_eff;
   logic [31:0]               next_config_checksum;
   logic [31:0]               next_state;
   logic [31:0]               next_refresh_count;
   logic [31:0]               next_settle_count;
   metering_pkg::settle_st_t  next_settle_st;
   logic                      next_state_valid;
   metering_pkg::reg_sel_t    sel;
   logic                      access;
   logic                      done;
   logic                      refresh_tick;
   logic [31:0]               cdt_ext;
   logic [35:0]               thr_full;
   logic [31:0]               fresh_state;
   logic signed [31:0]        irms [3];
   logic signed [31:0]        thr0 [3];
   logic signed [31:0]        thr1 [3];
   logic [2:0]                comp_in [3];
   metering_pkg::gain_sec_t   gain_sec [3];
   metering_pkg::comp_sec_t   comp_sec [3];

   assign sel          = reg_sel(paddr);
   assign access       = psel && penable && !pready;
   assign done         = psel && penable && pready;
   assign refresh_tick = (refresh_count == 32'h0);
   assign cdt_ext      = {{(32 - `CDT_BITS){cdt[`CDT_BITS-1]}}, cdt};
   assign thr_full     = {thr_high, thr_low};

   assign irms    = '{irms_a, irms_b, irms_c};
   assign thr0    = '{section_current_threshold_0_a, section_current_threshold_0_b,
                      section_current_threshold_0_c};
   assign thr1    = '{section_current_threshold_1_a, section_current_threshold_1_b,
                      section_current_threshold_1_c};
   assign comp_in = '{phase_comp_section_a, phase_comp_section_b, phase_comp_section_c};

   // Per-phase section decisions
   for (genvar ph = 0; ph < 3; ph++) begin : g_phase
      assign gain_sec[ph] = gain_section(irms[ph], thr0[ph], thr1[ph]);
      assign comp_sec[ph] = comp_clamp(comp_in[ph]);
   end

   always_comb begin
      fresh_state = 32'h0;
      fresh_state[`GAIN_C_LSB +: 2] = gain_sec[2];
      fresh_state[`GAIN_B_LSB +: 2] = gain_sec[1];
      fresh_state[`GAIN_A_LSB +: 2] = gain_sec[0];
      fresh_state[`COMP_C_LSB +: 3] = comp_sec[2];
      fresh_state[`COMP_B_LSB +: 3] = comp_sec[1];
      fresh_state[`COMP_A_LSB +: 3] = comp_sec[0];
   end

   // Register file and bus answer, one wait state
   always_comb begin
      next_thr_high        = thr_high;
      next_thr_low         = thr_low;
      next_cdt             = cdt;
      next_high_speed_mode = high_speed_mode;
      next_pready          = access;
      next_pslverr         = 1'b0;
      next_prdata          = 32'h0;
      if (access) begin
         next_pslverr = (sel == metering_pkg::SEL_NONE) ||
                        (pwrite && sel == metering_pkg::SEL_STATE);
         if (!pwrite) begin
            case (sel)
               metering_pkg::SEL_STATE: next_prdata = calibration_section_state;
               metering_pkg::SEL_CDT:   next_prdata = cdt_ext;
               metering_pkg::SEL_HIGH:  next_prdata = {14'h0, thr_high};
               metering_pkg::SEL_LOW:   next_prdata = {14'h0, thr_low};
               metering_pkg::SEL_MODE:  next_prdata = {30'h0, state_valid, high_speed_mode};
               default:                 next_prdata = 32'h0;
            endcase
         end
      end
      if (done && pwrite) begin
         case (sel)
            metering_pkg::SEL_CDT:  next_cdt = pwdata[`CDT_BITS-1:0];
            metering_pkg::SEL_HIGH: next_thr_high = pwdata[`THR_BITS-1:0];
            metering_pkg::SEL_LOW:  next_thr_low = pwdata[`THR_BITS-1:0];
            metering_pkg::SEL_MODE: next_high_speed_mode = pwdata[0];
            default:                next_cdt = cdt;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_high        <= `THR_RESET;
         thr_low         <= `THR_RESET;
         cdt             <= `CDT_RESET;
         high_speed_mode <= 1'b0;
         prdata          <= 32'h0;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
      end else begin
         thr_high        <= next_thr_high;
         thr_low         <= next_thr_low;
         cdt             <= next_cdt;
         high_speed_mode <= next_high_speed_mode;
         prdata          <= next_prdata;
         pready          <= next_pready;
         pslverr         <= next_pslverr;
      end
   end

   // Effective threshold and checksum contribution
   always_comb begin
      if (high_speed_mode) begin
         next_energy_threshold_eff = {thr_full, 14'h0};
      end else begin
         next_energy_threshold_eff = {14'h0, thr_full};
      end
      next_config_checksum = {14'h0, thr_high} + {14'h0, thr_low} + cdt_ext;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         energy_threshold_eff <= 50'h0;
         config_checksum      <= 32'h0;
      end else begin
         energy_threshold_eff <= next_energy_threshold_eff;
         config_checksum      <= next_config_checksum;
      end
   end

   // Periodic refresh and settling
   always_comb begin
      next_refresh_count = refresh_tick ? REFRESH_CYCLES - 32'h1 : refresh_count - 32'h1;
      next_state         = refresh_tick ? fresh_state : calibration_section_state;
      next_settle_st     = settle_st;
      next_settle_count  = settle_count;
      case (settle_st)
         metering_pkg::SETTLING: begin
            if (settle_count >= SETTLE_CYCLES - 32'h1) begin
               next_settle_st = metering_pkg::SETTLED;
            end else begin
               next_settle_count = settle_count + 32'h1;
            end
         end
         metering_pkg::SETTLED: next_settle_count = settle_count;
         default: next_settle_st = metering_pkg::SETTLING;
      endcase
      next_state_valid = (next_settle_st == metering_pkg::SETTLED);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_count             <= 32'h0;
         calibration_section_state <= 32'h0;
         settle_count              <= 32'h0;
         settle_st                 <= metering_pkg::SETTLING;
         state_valid               <= 1'b0;
      end else begin
         refresh_count             <= next_refresh_count;
         calibration_section_state <= next_state;
         settle_count              <= next_settle_count;
         settle_st                 <= next_settle_st;
         state_valid               <= next_state_valid;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_hs_scale: assert property (high_speed_mode && $stable(thr_full) |=>
      energy_threshold_eff == {$past(thr_full), 14'h0})
      else $error("high-speed threshold not scaled by 16384");
   a_word_write: assert property (done && pwrite && sel == metering_pkg::SEL_LOW |=>
      thr_low == $past(pwdata[`THR_BITS-1:0]) && $stable(thr_high))
      else $error("low threshold word write wrong");
   a_thr_pad: assert property (done && !pwrite &&
      (sel == metering_pkg::SEL_HIGH || sel == metering_pkg::SEL_LOW) |-> prdata[31:18] == 14'h0)
      else $error("threshold read upper bits not zero");
   a_checksum_sum: assert property (##1 config_checksum ==
      $past({14'h0, thr_high}) + $past({14'h0, thr_low}) + $past(cdt_ext))
      else $error("checksum does not follow thresholds");
   a_cdt_sign: assert property (done && !pwrite && sel == metering_pkg::SEL_CDT |->
      prdata == {{8{cdt[23]}}, cdt})
      else $error("current threshold read not sign-extended");
   a_cdt_checksum: assert property (cdt[23] |=> config_checksum ==
      $past({14'h0, thr_high}) + $past({14'h0, thr_low}) + $past({8'hff, cdt}))
      else $error("checksum ignores sign extension");
   a_state_ro: assert property (done && pwrite && sel == metering_pkg::SEL_STATE |->
      pslverr ##1 calibration_section_state ==
      ($past(refresh_tick) ? $past(fresh_state) : $past(calibration_section_state)))
      else $error("state register write not refused");
   a_field_codes: assert property (calibration_section_state[21:20] != 2'h3 &&
      calibration_section_state[17:16] != 2'h3 && calibration_section_state[13:12] != 2'h3 &&
      calibration_section_state[10:8] <= 3'h4 && calibration_section_state[6:4] <= 3'h4 &&
      calibration_section_state[2:0] <= 3'h4)
      else $error("section code out of range");
   a_refresh_gap: assert property (!refresh_tick |=> $stable(calibration_section_state))
      else $error("state changed between refreshes");
   a_refresh_next: assert property (refresh_count == 32'h1 |=> refresh_tick)
      else $error("refresh tick missed");
   a_gain_select: assert property (refresh_tick |=>
      calibration_section_state[13:12] == $past(gain_sec[0]) &&
      calibration_section_state[21:20] == $past(gain_sec[2]))
      else $error("gain section not latched at refresh");
   a_settle_wait: assert property (state_valid |-> settle_count == SETTLE_CYCLES - 32'h1)
      else $error("state valid before settling");
   a_reserved: assert property ((calibration_section_state & 32'hffccc888) == 32'h0)
      else $error("reserved state bits set");

   c_read_state: cover property (done && !pwrite && sel == metering_pkg::SEL_STATE);
   c_write_high: cover property (done && pwrite && sel == metering_pkg::SEL_HIGH);
   c_unmapped:   cover property (done && pslverr);
   c_settled:    cover property ($rose(state_valid));
endmodule

//--- metering_host_model.sv
// APB master model standing in for the host microcontroller
// Assumes one pclk domain; the slave ends each access with pready
`timescale 1ns/1ps
module metering_host_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [17:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic stuck;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h00000;
      pwdata = 32'h00000000;
      stuck = 1'b0;
   end
   // One transfer; register index times four gives the byte address
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) stuck = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show no stale value
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule

//--- tb_metering_threshold_section_state.sv
// Self-checking bench for the threshold and section state block
// Assumes metering_defines.svh and a 100 MHz pclk with shortened counts
`timescale 1ns/1ps
`include "metering_defines.svh"
module tb_metering_threshold_section_state;
   localparam int REFRESH = 16;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic               high_speed_mode, state_valid, err;
   logic        [17:0] paddr;
   logic        [31:0] pwdata, prdata, config_checksum, v, hi, lo, cdt;
   logic        [49:0] energy_threshold_eff;
   logic signed [31:0] irms [3], thr0 [3], thr1 [3];
   logic        [2:0]  comp [3];
   int                 errors, cmp_count, a, b, c, n;

   metering_threshold_section_state #(.REFRESH_CYCLES(REFRESH), .SETTLE_CYCLES(40))
   i_metering_threshold_section_state (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irms_a(irms[0]), .irms_b(irms[1]), .irms_c(irms[2]),
      .section_current_threshold_0_a(thr0[0]), .section_current_threshold_0_b(thr0[1]),
      .section_current_threshold_0_c(thr0[2]), .section_current_threshold_1_a(thr1[0]),
      .section_current_threshold_1_b(thr1[1]), .section_current_threshold_1_c(thr1[2]),
      .phase_comp_section_a(comp[0]), .phase_comp_section_b(comp[1]),
      .phase_comp_section_c(comp[2]), .energy_threshold_eff(energy_threshold_eff),
      .config_checksum(config_checksum), .high_speed_mode(high_speed_mode),
      .state_valid(state_valid));

   metering_host_model i_metering_host_model (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      i_metering_host_model.xfer(1'b1, idx, d, v, err);
      if (i_metering_host_model.stuck === 1'b1) summarize();
   endtask
   task automatic rd(input logic [15:0] idx, output logic [31:0] d);
      i_metering_host_model.xfer(1'b0, idx, 32'h00000000, d, err);
      if (i_metering_host_model.stuck === 1'b1) summarize();
   endtask
   function automatic logic [31:0] exp_state();
      logic [1:0] g [3];
      logic [2:0] s [3];
      for (int p = 0; p < 3; p++) begin
         g[p] = (irms[p] < thr0[p]) ? 2'h0 : (irms[p] > thr1[p]) ? 2'h2 : 2'h1;
         s[p] = (comp[p] > 3'h4) ? 3'h4 : comp[p];
      end
      return {10'h000, g[2], 2'h0, g[1], 2'h0, g[0], 1'b0, s[2], 1'b0, s[1], 1'b0, s[0]};
   endfunction
   task automatic summarize();
      if (i_metering_host_model.stuck === 1'b1) errors++;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      presetn = 1'b0;
      for (int p = 0; p < 3; p++) begin
         irms[p] = 32'h00000000;
         thr0[p] = 32'h00000000;
         thr1[p] = 32'h00000000;
         comp[p] = 3'h0;
      end
      errors = 0;
      cmp_count = 0;
      void'($urandom(32'h0bd218d9));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(state_valid, 1'b0);
      // Word boundaries, sign boundaries and both modes
      for (int k = 0; k < 6; k++) begin
         hi = (k == 0) ? 32'hffffffff : $urandom;
         lo = (k == 1) ? 32'hffffffff : $urandom;
         cdt = (k == 2) ? 32'h00800000 : (k == 3) ? 32'h007fffff : $urandom;
         wr(`IDX_THR_HIGH, hi);
         wr(`IDX_THR_LOW, lo);
         wr(`IDX_CDT, cdt);
         wr(`IDX_MODE, {31'h0, k[0]});
         rd(`IDX_THR_HIGH, v);
         chk(v, {14'h0000, hi[17:0]});
         rd(`IDX_THR_LOW, v);
         chk(v, {14'h0000, lo[17:0]});
         rd(`IDX_CDT, v);
         chk(v, {{8{cdt[23]}}, cdt[23:0]});
         chk(high_speed_mode, k[0]);
         chk(energy_threshold_eff, {14'h0, hi[17:0], lo[17:0]} << (k[0] ? 14 : 0));
         chk(config_checksum, 32'({14'h0, hi[17:0]} + {14'h0, lo[17:0]}
             + {{8{cdt[23]}}, cdt[23:0]}));
      end
      wr(`IDX_STATE, 32'hffffffff);
      chk(err, 1'b1);
      rd(16'h0100, v);
      chk({err, v}, {1'b1, 32'h00000000});
      n = 0;
      while (state_valid !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(state_valid, 1'b1);
      if (state_valid !== 1'b1) summarize();
      rd(`IDX_MODE, v);
      chk(v, 32'h00000003);
      // Threshold equality corners first, then random currents
      for (int k = 0; k < 12; k++) begin
         @(posedge pclk);
         for (int p = 0; p < 3; p++) begin
            a = $urandom_range(1000);
            b = a + $urandom_range(1000);
            c = (k == 0) ? a : (k == 1) ? b : (k == 2) ? a - 1 : $urandom_range(2500);
            thr0[p] <= 32'(a);
            thr1[p] <= 32'(b);
            irms[p] <= 32'(c);
            comp[p] <= (p == 0) ? 3'(k) : 3'($urandom_range(7));
         end
         repeat (REFRESH + 4) @(posedge pclk);
         rd(`IDX_STATE, v);
         chk(v, exp_state());
         wr(`IDX_STATE, ~v);
         rd(`IDX_STATE, v);
         chk(v, exp_state());
      end
      // Mid-run reset clears every register
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({state_valid, high_speed_mode, pready, pslverr, config_checksum}, 36'h0);
      chk(energy_threshold_eff, 50'h0);
      presetn <= 1'b1;
      rd(`IDX_THR_LOW, v);
      chk({err, v}, 33'h0);
      summarize();
   end
endmodule
